// File: hw/pfp_top.sv
// parallel programming port of the code flash, with a small status slave
// assumes programmer pins are asynchronous; Avalon-MM master on i_clk
//
// How it works
// - lock one blocks code writes, both locks also make verify reads return all ones.
// - only chip erase clears a programmed lock bit.
// - the array starts with every byte reading all ones.
// - a byte write can only clear bits, so a non-blank byte needs an erase first.
// - the address counter clears on reset pin rise and steps on each step pin rise.
// - an accepted write runs to completion on its own internal timer.
// - with the reset pin at logic high, read mode and no write in progress, the addressed byte is driven out.
// - while a write runs, reading its byte returns the top data bit inverted.
// - ready/busy goes low after the strobe rises and high when the write ends.
// - chip erase, with strobe held low long enough, sets all bytes and clears both locks.
// - signature mode returns identification bytes for addresses zero to two.
// - lock bits have no direct readout anywhere.
//
// The register addresses and the Avalon-MM register port were decided locally.
module pfp_top
  import pfp_pkg::*;
#(
  parameter int unsigned WRITE_CYC = WRITE_CYCLES,
  parameter int unsigned ERASE_CYC = ERASE_CYCLES,
  parameter logic [7:0] SIG0 = SIG_BYTE0,
  parameter logic [7:0] SIG1 = SIG_BYTE1,
  parameter logic [7:0] SIG2 = SIG_BYTE2
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_reset_vpp_pin,
  input wire logic i_reset_vpp_hv,
  input wire logic i_address_step_pin,
  input wire logic i_prog_strobe_pin,
  input wire logic i_mode_sel_a,
  input wire logic i_mode_sel_b,
  input wire logic i_mode_sel_c,
  input wire logic i_mode_sel_d,
  input wire logic [7:0] i_data_port,
  output logic [7:0] o_data_port,
  output logic o_data_port_oe,
  output logic o_ready_busy_pin,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest
);
  localparam int EW = 2 + ADDR_W + DATA_W;
  localparam int PW = $clog2(FIFO_DEPTH);

  // reset release
  logic arst_q1;
  logic rst_n;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      arst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      arst_q1 <= 1'b1;
      rst_n <= arst_q1;
    end
  end

  // pin synchronisers
  logic [15:0] pin_raw;
  logic [15:0] pin_q1;
  logic [15:0] pin_q2;
  logic rst_hi_d;
  logic step_d;
  logic strobe_d;
  assign pin_raw = {i_reset_vpp_pin, i_reset_vpp_hv, i_address_step_pin, i_prog_strobe_pin,
                    i_mode_sel_a, i_mode_sel_b, i_mode_sel_c, i_mode_sel_d, i_data_port};
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      // strobe idles high, so its stages reset high too
      pin_q1 <= 16'h1000;
      pin_q2 <= 16'h1000;
      rst_hi_d <= 1'b0;
      step_d <= 1'b0;
      strobe_d <= 1'b1;
    end else begin
      pin_q1 <= pin_raw;
      pin_q2 <= pin_q1;
      rst_hi_d <= pin_q2[15];
      step_d <= pin_q2[13];
      strobe_d <= pin_q2[12];
    end
  end

  logic rst_hi;
  logic hv;
  logic strobe;
  logic [3:0] mode;
  logic [7:0] din;
  logic rst_rise;
  logic step_rise;
  logic strobe_rise;
  assign rst_hi = pin_q2[15];
  assign hv = pin_q2[14];
  assign strobe = pin_q2[12];
  assign mode = pin_q2[11:8];
  assign din = pin_q2[7:0];
  assign rst_rise = rst_hi & ~rst_hi_d;
  assign step_rise = pin_q2[13] & ~step_d;
  assign strobe_rise = strobe & ~strobe_d;

  // address counter and erase strobe timer
  // eleven-bit counter
  logic [ADDR_W-1:0] addr_cnt;
  logic [ADDR_W-1:0] next_addr_cnt;
  logic [31:0] erase_cnt;
  logic [31:0] next_erase_cnt;
  logic port_en;
  always_comb begin
    next_addr_cnt = addr_cnt;
    if (rst_rise) begin
      next_addr_cnt = '0;
    end else if (step_rise) begin
      next_addr_cnt = addr_cnt + 1'b1;
    end
    next_erase_cnt = 32'h0000_0000;
    if (!strobe && hv && mode == MODE_ERASE) begin
      next_erase_cnt = (erase_cnt >= 32'(ERASE_CYC)) ? erase_cnt : erase_cnt + 32'h0000_0001;
    end
  end
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_cnt <= '0;
      erase_cnt <= 32'h0000_0000;
    end else begin
      addr_cnt <= next_addr_cnt;
      erase_cnt <= next_erase_cnt;
    end
  end

  // two-entry request buffer, drained by the sequencer
  logic [EW-1:0] fifo_mem [FIFO_DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] fifo_cnt;
  logic [PW-1:0] next_wr_ptr;
  logic [PW-1:0] next_rd_ptr;
  logic [PW:0] next_fifo_cnt;
  logic fifo_ready;
  logic fifo_valid;
  logic push;
  logic pop;
  logic [1:0] push_kind;
  logic push_ok;
  // nonvolatile: only the start of simulation and a chip erase clear them
  logic lock_one = 1'b0;
  logic lock_two = 1'b0;
  assign fifo_ready = fifo_cnt != (PW+1)'(FIFO_DEPTH);
  assign fifo_valid = fifo_cnt != '0;
  always_comb begin
    push_kind = KIND_CODE;
    push_ok = 1'b0;
    // strobe rise with high voltage takes the request
    if (strobe_rise && hv && port_en) begin
      if (mode == MODE_WRITE_CODE) begin
        // code writes refused under lock one
        push_ok = !lock_one;
      end else if (mode == MODE_LOCK_ONE) begin
        push_kind = KIND_LOCK_ONE;
        push_ok = 1'b1;
      end else if (mode == MODE_LOCK_TWO) begin
        push_kind = KIND_LOCK_TWO;
        push_ok = 1'b1;
      end else if (mode == MODE_ERASE) begin
        push_kind = KIND_ERASE;
        push_ok = erase_cnt >= 32'(ERASE_CYC);
      end
    end
  end
  assign push = push_ok & fifo_ready;
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (push) begin
      next_wr_ptr = (wr_ptr == PW'(FIFO_DEPTH-1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == PW'(FIFO_DEPTH-1)) ? '0 : rd_ptr + 1'b1;
    end
    next_fifo_cnt = fifo_cnt + (PW+1)'(push) - (PW+1)'(pop);
  end
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fifo_cnt <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      fifo_cnt <= next_fifo_cnt;
    end
  end
  always_ff @(posedge i_clk) begin
    if (push) begin
      fifo_mem[wr_ptr] <= {push_kind, addr_cnt, din};
    end
  end

  // self-timed write and erase sequencer
  pfp_seq_t state;
  pfp_seq_t next_state;
  logic [1:0] cur_kind;
  logic [ADDR_W-1:0] cur_addr;
  logic [7:0] cur_data;
  logic [31:0] timer;
  logic [1:0] next_cur_kind;
  logic [ADDR_W-1:0] next_cur_addr;
  logic [7:0] next_cur_data;
  logic [31:0] next_timer;
  logic next_lock_one;
  logic next_lock_two;
  logic mem_we;
  logic [ADDR_W-1:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic [ADDR_W-1:0] mem_raddr;
  assign pop = (state == S_IDLE) & fifo_valid;
  always_comb begin
    next_state = state;
    next_cur_kind = cur_kind;
    next_cur_addr = cur_addr;
    next_cur_data = cur_data;
    next_timer = timer;
    next_lock_one = lock_one;
    next_lock_two = lock_two;
    mem_we = 1'b0;
    mem_waddr = cur_addr;
    mem_wdata = cur_data;
    case (state)
      S_IDLE: begin
        if (fifo_valid) begin
          {next_cur_kind, next_cur_addr, next_cur_data} = fifo_mem[rd_ptr];
          next_state = (fifo_mem[rd_ptr][EW-1 -: 2] == KIND_ERASE) ? S_ERASE : S_FETCH;
          if (fifo_mem[rd_ptr][EW-1 -: 2] == KIND_ERASE) begin
            next_cur_addr = '0;
          end
        end
      end
      S_FETCH: begin
        next_timer = 32'(WRITE_CYC) - 32'h0000_0001;
        next_state = S_WAIT;
      end
      S_WAIT: begin
        next_timer = timer - 32'h0000_0001;
        if (timer == 32'h0000_0000) begin
          next_state = S_COMMIT;
        end
      end
      S_COMMIT: begin
        next_state = S_IDLE;
        if (cur_kind == KIND_CODE) begin
          mem_we = 1'b1;
          mem_wdata = mem_rdata & cur_data;
        end else if (cur_kind == KIND_LOCK_ONE) begin
          next_lock_one = 1'b1;
        end else begin
          next_lock_two = 1'b1;
        end
      end
      S_ERASE: begin
        // sweep every byte back to erased
        mem_we = 1'b1;
        mem_wdata = ERASED_BYTE;
        next_cur_addr = cur_addr + 1'b1;
        if (cur_addr == '1) begin
          next_lock_one = 1'b0;
          next_lock_two = 1'b0;
          next_state = S_IDLE;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      cur_kind <= KIND_CODE;
      cur_addr <= '0;
      cur_data <= 8'h00;
      timer <= 32'h0000_0000;
    end else begin
      state <= next_state;
      cur_kind <= next_cur_kind;
      cur_addr <= next_cur_addr;
      cur_data <= next_cur_data;
      timer <= next_timer;
    end
  end
  // system reset leaves the locks alone
  always_ff @(posedge i_clk) begin
    lock_one <= next_lock_one;
    lock_two <= next_lock_two;
  end

  assign mem_raddr = (state == S_IDLE || state == S_ERASE) ? addr_cnt : cur_addr;
  pfp_mem #(.AW(ADDR_W), .DW(DATA_W)) u_mem (
    .i_clk(i_clk),
    .i_we(mem_we),
    .i_waddr(mem_waddr),
    .i_wdata(mem_wdata),
    .i_raddr(mem_raddr),
    .o_rdata(mem_rdata)
  );

  // pin outputs
  logic busy;
  logic poll_hit;
  logic lock_both;
  logic [7:0] next_data_out;
  logic next_oe;
  assign busy = fifo_valid | (state != S_IDLE);
  assign poll_hit = (state != S_IDLE) && (state != S_ERASE) && (cur_kind == KIND_CODE)
                    && (addr_cnt == cur_addr);
  assign lock_both = lock_one & lock_two;
  always_comb begin
    next_oe = port_en & rst_hi & ~hv & (mode == MODE_READ_CODE || mode == MODE_SIGNATURE);
    next_data_out = mem_rdata;
    if (mode == MODE_SIGNATURE) begin
      next_data_out = (addr_cnt == 11'h000) ? SIG0 : (addr_cnt == 11'h001) ? SIG1 : SIG2;
    end else if (lock_both) begin
      next_data_out = ERASED_BYTE;
    end else if (poll_hit) begin
      next_data_out = {~cur_data[7], cur_data[6:0]};
    end
  end
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_data_port <= ERASED_BYTE;
      o_data_port_oe <= 1'b0;
      o_ready_busy_pin <= 1'b1;
    end else begin
      o_data_port <= next_data_out;
      o_data_port_oe <= next_oe;
      o_ready_busy_pin <= ~busy;
    end
  end

  // Avalon-MM slave: one wait cycle, then answer
  logic ack;
  logic next_ack;
  logic next_port_en;
  logic [31:0] next_readdata;
  always_comb begin
    next_ack = (i_avs_read | i_avs_write) & ~ack;
    next_port_en = port_en;
    next_readdata = 32'h0000_0000;
    // write lands on the edge after the wait ends, while waitrequest is low
    if (ack && i_avs_write && i_avs_address == REG_CTRL && i_avs_byteenable[0]) begin
      next_port_en = i_avs_writedata[CTRL_PORT_EN_BIT];
    end
    if (next_ack && i_avs_read) begin
      if (i_avs_address == REG_CTRL) begin
        next_readdata[CTRL_PORT_EN_BIT] = port_en;
      end else if (i_avs_address == REG_STATUS) begin
        next_readdata[STATUS_BUSY_BIT] = busy;
        next_readdata[STATUS_FULL_BIT] = ~fifo_ready;
        next_readdata[STATUS_ADDR_LSB +: ADDR_W] = addr_cnt;
      end
    end
  end
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
      port_en <= CTRL_PORT_EN_RESET;
      o_avs_readdata <= 32'h0000_0000;
      o_avs_waitrequest <= 1'b1;
    end else begin
      ack <= next_ack;
      port_en <= next_port_en;
      o_avs_readdata <= next_readdata;
      o_avs_waitrequest <= ~next_ack;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  a_lock_blocks_write: assert property (push && push_kind == KIND_CODE |-> !lock_one)
    else $error("code write accepted under lock");
  a_verify_blocked: assert property (
    (lock_both && mode == MODE_READ_CODE) [*3] |-> o_data_port == ERASED_BYTE)
    else $error("verify not blocked");
  a_lock_clear_erase: assert property (
    ($fell(lock_one) || $fell(lock_two)) |-> $past(state) == S_ERASE)
    else $error("lock cleared outside erase");
  a_and_program: assert property (
    (mem_we && state == S_COMMIT) |-> (mem_wdata & ~cur_data) == 8'h00)
    else $error("write set a cleared bit");
  a_addr_clear: assert property (rst_rise |=> addr_cnt == 11'h000)
    else $error("counter not cleared");
  a_addr_step: assert property (
    step_rise && !rst_rise |=> addr_cnt == $past(addr_cnt) + 11'h001)
    else $error("counter did not step");
  a_write_timed: assert property (
    $rose(state == S_WAIT) |-> timer == 32'(WRITE_CYC) - 32'h0000_0001)
    else $error("write timer wrong");
  a_poll_complement: assert property (
    (poll_hit && !lock_both && mode == MODE_READ_CODE) [*3] |-> o_data_port[7] != cur_data[7])
    else $error("poll bit not inverted");
  a_busy_low: assert property (push |-> ##2 !o_ready_busy_pin)
    else $error("busy not shown");
  a_busy_ends: assert property ($fell(busy) |=> o_ready_busy_pin)
    else $error("ready not restored");
  a_erase_fill: assert property (
    state == S_ERASE |-> mem_we && mem_wdata == ERASED_BYTE)
    else $error("erase wrote wrong data");
  a_sig_read: assert property (
    (mode == MODE_SIGNATURE && addr_cnt == 11'h000) [*2] |=> o_data_port == SIG0)
    else $error("signature byte wrong");

  c_code_write: cover property (state == S_COMMIT && cur_kind == KIND_CODE);
  c_erase_done: cover property (state == S_ERASE && cur_addr == '1);
  c_poll: cover property (poll_hit && o_data_port_oe);
  c_buffer_full: cover property (!fifo_ready);
endmodule : pfp_top

// File: common/pfp_pkg.sv
// constants shared by the parallel flash programming port
// assumes a single 25 MHz system clock
package pfp_pkg;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 2;
  localparam int CLK_MHZ = 25;
  localparam int WRITE_TIME_US = 1200;
  localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
  localparam int ERASE_TIME_US = 10000;
  localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // mode pins packed as {a, b, c, d}
  localparam logic [3:0] MODE_WRITE_CODE = 4'h7;
  localparam logic [3:0] MODE_READ_CODE = 4'h3;
  localparam logic [3:0] MODE_LOCK_ONE = 4'hF;
  localparam logic [3:0] MODE_LOCK_TWO = 4'hC;
  localparam logic [3:0] MODE_ERASE = 4'h8;
  localparam logic [3:0] MODE_SIGNATURE = 4'h0;
  localparam logic [1:0] KIND_CODE = 2'h0;
  localparam logic [1:0] KIND_LOCK_ONE = 2'h1;
  localparam logic [1:0] KIND_LOCK_TWO = 2'h2;
  localparam logic [1:0] KIND_ERASE = 2'h3;
  // identification bytes, values arbitrary
  localparam logic [7:0] SIG_BYTE0 = 8'h5A;
  localparam logic [7:0] SIG_BYTE1 = 8'hA5;
  localparam logic [7:0] SIG_BYTE2 = 8'h3C;
  // register map, byte addresses
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int CTRL_PORT_EN_BIT = 0;
  localparam logic CTRL_PORT_EN_RESET = 1'b1;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_FULL_BIT = 1;
  localparam int STATUS_ADDR_LSB = 16;
  typedef enum logic [2:0] {S_IDLE, S_FETCH, S_WAIT, S_COMMIT, S_ERASE} pfp_seq_t;
endpackage : pfp_pkg

// File: hw/pfp_mem.sv
// code array storage: one write port, one registered read port
// assumes a single clock; contents start erased
module pfp_mem
  import pfp_pkg::*;
#(
  parameter int AW = 11,
  parameter int DW = 8
) (
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [DW-1:0] o_rdata
);
  // delivered erased; no reset, contents are nonvolatile
  logic [DW-1:0] mem [2**AW] = '{default: DW'(ERASED_BYTE)};

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule : pfp_mem

// File: sim/pfp_prog_model.sv
// external programmer model driving the flash port pins
// assumes the port samples all pins through two flops on i_clk
module pfp_prog_model
  import pfp_pkg::*;
(
  input wire logic i_clk,
  input wire logic [7:0] i_dev_data,
  input wire logic i_dev_oe,
  output logic o_rst,
  output logic o_hv,
  output logic o_step,
  output logic o_strobe,
  output logic [3:0] o_mode,
  output logic [7:0] o_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drv;
  logic [7:0] dat;
  // released line shows the inverse of what was last driven
  assign o_data = i_dev_oe ? i_dev_data : (drv ? dat : ~dat);
  initial begin
    o_rst = 1'b0;
    o_hv = 1'b0;
    o_step = 1'b0;
    o_strobe = 1'b0;
    o_mode = MODE_READ_CODE;
    drv = 1'b0;
    dat = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick
  task automatic power_up();
    o_rst <= 1'b1;
    tick(4);
    o_strobe <= 1'b1;
    tick(4);
  endtask : power_up
  task automatic rst_pulse();
    o_hv <= 1'b0;
    o_rst <= 1'b0;
    tick(4);
    o_rst <= 1'b1;
    tick(4);
  endtask : rst_pulse
  task automatic step();
    o_step <= 1'b1;
    tick(3);
    o_step <= 1'b0;
    tick(3);
  endtask : step
  task automatic wr(input logic [3:0] mode, input logic [7:0] d, input int low);
    drv <= 1'b1;
    dat <= d;
    o_mode <= mode;
    o_hv <= 1'b1;
    tick(3);
    o_strobe <= 1'b0;
    tick(low);
    o_strobe <= 1'b1;
    tick(3);
  endtask : wr
  task automatic rd(input logic [3:0] mode, output logic [7:0] d);
    drv <= 1'b0;
    o_hv <= 1'b0;
    o_mode <= mode;
    tick(6);
    d = o_data;
  endtask : rd
endmodule : pfp_prog_model

// File: sim/parallel_flash_programming_port_tb.sv
// self-checking bench for the flash programming port
// assumes the programmer model in pfp_prog_model and the status slave on Avalon-MM
module parallel_flash_programming_port_tb
  import pfp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WR_CYC = 80;
  localparam int ER_CYC = 10;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic rst, hv, step, strobe, dev_oe, rdy, av_wait;
  logic [3:0] mode;
  logic [7:0] pin_data, dev_data, b;
  logic [3:0] av_addr = 4'h0;
  logic av_rd = 1'b0;
  logic av_wr = 1'b0;
  logic [31:0] av_wdata = 32'h0000_0000;
  logic [31:0] av_rdata, r;
  logic [7:0] sig [3] = '{SIG_BYTE0, SIG_BYTE1, SIG_BYTE2};
  int err_count = 0;
  int n_compared = 0;
  always #20 clk = ~clk;
  pfp_top #(.WRITE_CYC(WR_CYC), .ERASE_CYC(ER_CYC)) i_dut (
    .i_clk(clk), .i_arst_n(arst_n), .i_reset_vpp_pin(rst), .i_reset_vpp_hv(hv),
    .i_address_step_pin(step), .i_prog_strobe_pin(strobe),
    .i_mode_sel_a(mode[3]), .i_mode_sel_b(mode[2]), .i_mode_sel_c(mode[1]),
    .i_mode_sel_d(mode[0]), .i_data_port(pin_data), .o_data_port(dev_data),
    .o_data_port_oe(dev_oe), .o_ready_busy_pin(rdy), .i_avs_address(av_addr),
    .i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_writedata(av_wdata),
    .i_avs_byteenable(4'hF), .o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait));
  pfp_prog_model i_prog (
    .i_clk(clk), .i_dev_data(dev_data), .i_dev_oe(dev_oe), .o_rst(rst), .o_hv(hv),
    .o_step(step), .o_strobe(strobe), .o_mode(mode), .o_data(pin_data));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] wd,
                    output logic [31:0] d);
    av_addr <= a;
    av_wdata <= wd;
    av_wr <= w;
    av_rd <= ~w;
    @(posedge clk);
    while (av_wait !== 1'b0) begin
      @(posedge clk);
    end
    d = av_rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    @(posedge clk);
  endtask : av
  task automatic vfy(input logic [7:0] exp);
    i_prog.rd(MODE_READ_CODE, b);
    check(b, exp);
  endtask : vfy
  task automatic wait_ready();
    int n;
    repeat (3) @(posedge clk);
    for (n = 0; n < 4000; n++) begin
      @(posedge clk);
      if (rdy === 1'b1) break;
    end
    check(rdy, 1'b1);
  endtask : wait_ready
  task automatic done(input string s);
    $display("test %0s done", s);
  endtask : done
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
    i_prog.power_up();
    av(1'b0, REG_CTRL, 32'h0000_0000, r);
    check(r, 32'h0000_0001);
    av(1'b0, REG_STATUS, 32'h0000_0000, r);
    check(r, 32'h0000_0000);
    av(1'b0, 4'h8, 32'h0000_0000, r);
    check(r, 32'h0000_0000);
    check(rdy, 1'b1);
    done("reset");
    vfy(ERASED_BYTE);
    i_prog.wr(MODE_WRITE_CODE, 8'hA5, 3);
    repeat (2) @(posedge clk);
    check(rdy, 1'b0);
    vfy(8'h25);
    wait_ready();
    vfy(8'hA5);
    done("write");
    i_prog.step();
    av(1'b0, REG_STATUS, 32'h0000_0000, r);
    check(r[STATUS_ADDR_LSB +: ADDR_W], 32'h0000_0001);
    i_prog.wr(MODE_WRITE_CODE, 8'h3C, 3);
    wait_ready();
    i_prog.rst_pulse();
    av(1'b0, REG_STATUS, 32'h0000_0000, r);
    check(r[STATUS_ADDR_LSB +: ADDR_W], 32'h0000_0000);
    vfy(8'hA5);
    i_prog.step();
    vfy(8'h3C);
    i_prog.rst_pulse();
    i_prog.wr(MODE_WRITE_CODE, 8'hF0, 3);
    wait_ready();
    vfy(8'hA0);
    done("counter");
    i_prog.rst_pulse();
    for (int k = 0; k < 3; k++) begin
      i_prog.rd(MODE_SIGNATURE, b);
      check(b, sig[k]);
      i_prog.step();
    end
    done("signature");
    av(1'b1, REG_CTRL, 32'h0000_0000, r);
    av(1'b0, REG_CTRL, 32'h0000_0000, r);
    check(r, 32'h0000_0000);
    i_prog.wr(MODE_WRITE_CODE, 8'h00, 3);
    wait_ready();
    vfy(ERASED_BYTE);
    av(1'b1, REG_CTRL, 32'h0000_0001, r);
    done("disable");
    i_prog.wr(MODE_LOCK_ONE, 8'h00, 3);
    wait_ready();
    i_prog.wr(MODE_WRITE_CODE, 8'h00, 3);
    wait_ready();
    vfy(ERASED_BYTE);
    i_prog.rst_pulse();
    vfy(8'hA0);
    i_prog.wr(MODE_LOCK_TWO, 8'h00, 3);
    wait_ready();
    vfy(ERASED_BYTE);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    check(dev_oe, 1'b0);
    check(rdy, 1'b1);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    vfy(ERASED_BYTE);
    done("locks");
    i_prog.wr(MODE_ERASE, 8'h00, ER_CYC + 5);
    wait_ready();
    vfy(ERASED_BYTE);
    i_prog.step();
    vfy(ERASED_BYTE);
    i_prog.wr(MODE_WRITE_CODE, 8'h5A, 3);
    wait_ready();
    vfy(8'h5A);
    done("erase");
    i_prog.step();
    for (int k = 0; k < 4; k++) begin
      i_prog.wr(MODE_WRITE_CODE, 8'(8'h20 + k), 3);
      i_prog.step();
    end
    av(1'b0, REG_STATUS, 32'h0000_0000, r);
    check(r[STATUS_FULL_BIT], 1'b1);
    wait_ready();
    i_prog.rst_pulse();
    i_prog.step();
    i_prog.step();
    for (int k = 0; k < 4; k++) begin
      vfy(k < 3 ? 8'(8'h20 + k) : ERASED_BYTE);
      i_prog.step();
    end
    done("buffer");
    report_and_stop();
  end
endmodule : parallel_flash_programming_port_tb
